//--- hw/afh_pkg.sv
package afh_pkg;
	// most severe action has the lowest code, so a minimum picks the winner
	typedef enum logic [1:0] {
		AFH_ACT_SHUTDOWN = 2'h0,
		AFH_ACT_DISABLE = 2'h1,
		AFH_ACT_STOP = 2'h2,
		AFH_ACT_STATUS = 2'h3
	} afh_action_e;
	localparam afh_action_e AFH_ACT_RESET = AFH_ACT_DISABLE;
	localparam int AFH_NFAULT = 8;
	localparam int AFH_SELW = 3;
	localparam int AFH_DW = 16;
	localparam int AFH_CNTW = 32;
	// fault indices
	localparam int AFH_F_DRIVE = 0;
	localparam int AFH_F_NOISE = 1;
	localparam int AFH_F_LOSS = 2;
	localparam int AFH_F_POSERR = 3;
	localparam int AFH_F_SOFTOT = 4;
	localparam int AFH_F_DRVTHERM = 5;
	localparam int AFH_F_MOTTHERM = 6;
	localparam int AFH_F_HARDOT = 7;
	// fault types present per axis flavour
	localparam logic [7:0] AFH_SUPPORT_ANALOG = 8'h1f;
	localparam logic [7:0] AFH_SUPPORT_NET = 8'hfe;
	typedef enum logic [4:0] {
		AFH_ST_RUN = 5'h01,
		AFH_ST_HALT = 5'h02,
		AFH_ST_HELD = 5'h04,
		AFH_ST_TSTOP = 5'h08,
		AFH_ST_OFF = 5'h10
	} afh_state_e;
endpackage

//--- hw/afh_ramp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface afh_ramp_if #(parameter int W = 16);
	logic load;
	logic signed [W-1:0] velStart;
	logic signed [W-1:0] decel;
	logic signed [W-1:0] vel;
	logic stopped;
	modport ctrl(output load, output velStart, output decel,
		input vel, input stopped);
	modport ramp(input load, input velStart, input decel,
		output vel, output stopped);
endinterface
`default_nettype wire

//--- hw/afh_decel_ramp.sv
`timescale 1ns/1ps
`default_nettype none
module afh_decel_ramp #(parameter int W = 16) (
	input wire logic clock,
	input wire logic rst_b,
	afh_ramp_if.ramp rp
);
	import afh_pkg::*;
	logic signed [W-1:0] vel_reg;
	logic signed [W-1:0] vel_next;

	// decel is taken as a positive rate per update
	always_comb begin
		if (rp.load) begin
			vel_next = rp.velStart;
		end else if (vel_reg > rp.decel) begin
			vel_next = W'(vel_reg - rp.decel);
		end else if (vel_reg < -rp.decel) begin
			vel_next = W'(vel_reg + rp.decel);
		end else begin
			vel_next = '0;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			vel_reg <= '0;
		end else begin
			vel_reg <= vel_next;
		end
	end

	assign rp.vel = vel_reg;
	assign rp.stopped = (vel_reg == '0);
endmodule
`default_nettype wire

//--- hw/afh_fault_core.sv
// Summary of operation
// - each fault type has its own action: shutdown, disable, stop, status
// - shutdown drops servo loop and drive enable at once, zeroes amp
// - analog axis disable drive does the same immediate drop
// - networked disable drive brakes by stopping torque, ignores reference
// - torque stop ends at standstill or time limit, whichever first
// - stop motion ramps command to zero, enables stay on
// - after a stop-motion halt, moves are rejected until faults clear
// - status only just reports the fault, no automatic action
// - drive fault needs enabled input, servo axis; shutdown or disable
// - feedback noise raises a fault, any action allowed
// - feedback loss raises a fault, any action allowed
// - servo axis position error above tolerance raises a fault
// - soft overtravel faults only with soft limits enabled on servo axis
// - analog axis has five fault types, networked axis has seven
`timescale 1ns/1ps
`default_nettype none
module afh_fault_core #(
	parameter int W = afh_pkg::AFH_DW
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic axisIsNet,
	input wire logic servoAxis,
	input wire logic driveFaultInEn,
	input wire logic softLimitEn,
	input wire logic [afh_pkg::AFH_NFAULT-1:0] faultPin,
	input wire logic signed [W-1:0] posError,
	input wire logic [W-1:0] posTolerance,
	input wire logic signed [W-1:0] fbVel,
	input wire logic [W-1:0] standstillTol,
	input wire logic signed [W-1:0] servoOut,
	input wire logic signed [W-1:0] stopTorque,
	input wire logic [afh_pkg::AFH_CNTW-1:0] stopTimeCycles,
	input wire logic signed [W-1:0] maxDecel,
	input wire logic faultClear,
	input wire logic cfgWrEn,
	input wire logic [afh_pkg::AFH_SELW-1:0] cfgSel,
	input wire afh_pkg::afh_action_e cfgWrData,
	input wire logic moveReq,
	input wire logic signed [W-1:0] moveVel,
	output logic servoEnable,
	output logic driveEnable,
	output logic signed [W-1:0] ampCmd,
	output logic signed [W-1:0] cmdVel,
	output logic moveAccepted,
	output logic moveRejected,
	output logic [afh_pkg::AFH_NFAULT-1:0] faultStatus,
	output afh_pkg::afh_action_e cfgRdData
);
	import afh_pkg::*;

	function automatic logic [W-1:0] magOf(input logic signed [W-1:0] v);
		magOf = v[W-1] ? W'(-v) : W'(v);
	endfunction

	afh_action_e act_reg [AFH_NFAULT];
	afh_action_e act_next [AFH_NFAULT];
	logic [AFH_NFAULT-1:0] meta_reg, sync_reg;
	logic [AFH_NFAULT-1:0] fault_reg, fault_next, det, support;
	afh_state_e state_reg, state_next;
	logic [AFH_CNTW-1:0] tcnt_reg, tcnt_next;
	logic servoEn_reg, servoEn_next, driveEn_reg, driveEn_next;
	logic signed [W-1:0] amp_reg, amp_next, vel_reg, vel_next;
	logic acc_reg, acc_next, rej_reg, rej_next;
	afh_action_e rd_reg, rd_next;
	afh_action_e sev;
	logic anyFault, standstill, tExpired, dropNow, torqueStop;

	afh_ramp_if #(.W(W)) rampBus();
	afh_decel_ramp #(.W(W)) uRamp(.clock(clock), .rst_b(rst_b),
		.rp(rampBus.ramp));

	// fault pins are asynchronous to the servo clock
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= faultPin;
			sync_reg <= meta_reg;
		end
	end

	// configuration store; drive fault forced to a drop action
	always_comb begin
		for (int i = 0; i < AFH_NFAULT; i++) begin
			act_next[i] = act_reg[i];
		end
		if (cfgWrEn) begin
			act_next[cfgSel] = cfgWrData;
			if (cfgSel == AFH_SELW'(AFH_F_DRIVE) && cfgWrData > AFH_ACT_DISABLE) begin
				act_next[cfgSel] = AFH_ACT_DISABLE;
			end
		end
		rd_next = act_next[cfgSel];
	end

	// detection and sticky latch; a new detection wins over a clear
	always_comb begin
		support = axisIsNet ? AFH_SUPPORT_NET : AFH_SUPPORT_ANALOG;
		det = sync_reg;
		det[AFH_F_DRIVE] = sync_reg[AFH_F_DRIVE] & driveFaultInEn
			& servoAxis;
		det[AFH_F_NOISE] = sync_reg[AFH_F_NOISE];
		det[AFH_F_LOSS] = sync_reg[AFH_F_LOSS];
		det[AFH_F_POSERR] = servoAxis & (magOf(posError) > posTolerance);
		det[AFH_F_SOFTOT] = sync_reg[AFH_F_SOFTOT] & softLimitEn
			& servoAxis;
		det[AFH_F_HARDOT] = sync_reg[AFH_F_HARDOT] & servoAxis;
		fault_next = (fault_reg & ~{AFH_NFAULT{faultClear}}) | (det & support);
	end

	// worst configured action among latched faults
	always_comb begin
		sev = AFH_ACT_STATUS;
		for (int i = 0; i < AFH_NFAULT; i++) begin
			if (fault_reg[i] && act_reg[i] < sev) begin
				sev = act_reg[i];
			end
		end
		anyFault = |fault_reg;
		standstill = magOf(fbVel) <= standstillTol;
		tExpired = tcnt_reg >= stopTimeCycles;
		// networked disable drive brakes first; analog drops at once
		torqueStop = anyFault && sev == AFH_ACT_DISABLE && axisIsNet;
		dropNow = anyFault && (sev == AFH_ACT_SHUTDOWN ||
			(sev == AFH_ACT_DISABLE && !axisIsNet));
	end

	always_comb begin
		state_next = state_reg;
		tcnt_next = '0;
		rampBus.load = 1'b0;
		rampBus.velStart = vel_reg;
		rampBus.decel = maxDecel;
		unique case (state_reg)
			AFH_ST_RUN, AFH_ST_HALT, AFH_ST_HELD: begin
				if (dropNow) begin
					state_next = AFH_ST_OFF;
				end else if (torqueStop) begin
					state_next = AFH_ST_TSTOP;
				end else if (state_reg == AFH_ST_RUN) begin
					// status only leaves the axis running
					if (anyFault && sev == AFH_ACT_STOP) begin
						state_next = AFH_ST_HALT;
						rampBus.load = 1'b1;
					end
				end else if (state_reg == AFH_ST_HALT) begin
					if (rampBus.stopped) begin
						state_next = AFH_ST_HELD;
					end
				end else if (!anyFault) begin
					state_next = AFH_ST_RUN;
				end
			end
			AFH_ST_TSTOP: begin
				tcnt_next = AFH_CNTW'(tcnt_reg + 1'b1);
				if (dropNow || standstill || tExpired) begin
					state_next = AFH_ST_OFF;
				end
			end
			AFH_ST_OFF: begin
				if (!anyFault) begin
					state_next = AFH_ST_RUN;
				end
			end
			default: begin
				state_next = AFH_ST_OFF;
			end
		endcase
	end

	// outputs follow the next state so a drop takes effect on the same edge
	always_comb begin
		servoEn_next = state_next != AFH_ST_OFF;
		driveEn_next = state_next != AFH_ST_OFF;
		amp_next = servoOut;
		vel_next = vel_reg;
		acc_next = 1'b0;
		rej_next = 1'b0;
		unique case (state_next)
			AFH_ST_RUN: begin
				acc_next = moveReq;
				if (moveReq) begin
					vel_next = moveVel;
				end
			end
			AFH_ST_HALT: begin
				rej_next = moveReq;
				vel_next = rampBus.load ? vel_reg : rampBus.vel;
			end
			AFH_ST_TSTOP: begin
				// brake against motion, command reference ignored
				rej_next = moveReq;
				vel_next = '0;
				amp_next = fbVel[W-1] ? stopTorque : W'(-stopTorque);
			end
			default: begin
				rej_next = moveReq;
				vel_next = '0;
				if (state_next == AFH_ST_OFF) begin
					amp_next = '0;
				end
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < AFH_NFAULT; i++) begin
				act_reg[i] <= AFH_ACT_RESET;
			end
			fault_reg <= '0;
			state_reg <= AFH_ST_RUN;
			tcnt_reg <= '0;
			servoEn_reg <= 1'b0;
			driveEn_reg <= 1'b0;
			amp_reg <= '0;
			vel_reg <= '0;
			acc_reg <= 1'b0;
			rej_reg <= 1'b0;
			rd_reg <= AFH_ACT_RESET;
		end else begin
			act_reg <= act_next;
			fault_reg <= fault_next;
			state_reg <= state_next;
			tcnt_reg <= tcnt_next;
			servoEn_reg <= servoEn_next;
			driveEn_reg <= driveEn_next;
			amp_reg <= amp_next;
			vel_reg <= vel_next;
			acc_reg <= acc_next;
			rej_reg <= rej_next;
			rd_reg <= rd_next;
		end
	end

	assign servoEnable = servoEn_reg;
	assign driveEnable = driveEn_reg;
	assign ampCmd = amp_reg;
	assign cmdVel = vel_reg;
	assign moveAccepted = acc_reg;
	assign moveRejected = rej_reg;
	assign faultStatus = fault_reg;
	assign cfgRdData = rd_reg;

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);

	a_shutdown_drop: assert property (
		anyFault && sev == AFH_ACT_SHUTDOWN
		|=> !servoEnable && !driveEnable && ampCmd == '0)
		else $error("shutdown did not drop the axis");
	a_analog_disable: assert property (anyFault && !axisIsNet &&
		sev == AFH_ACT_DISABLE |=> !servoEnable && !driveEnable)
		else $error("analog disable drive did not drop the axis");
	a_net_brake: assert property ((state_reg != AFH_ST_OFF) &&
		(state_reg != AFH_ST_TSTOP) && torqueStop |=> servoEnable &&
		state_reg == AFH_ST_TSTOP && ampCmd == ($past(fbVel[W-1]) ?
		stopTorque : W'(-stopTorque)))
		else $error("networked disable drive did not brake");
	a_brake_end: assert property (state_reg == AFH_ST_TSTOP &&
		(standstill || tExpired) |=> !servoEnable && !driveEnable)
		else $error("torque stop did not end");
	a_stop_enabled: assert property (
		anyFault && sev == AFH_ACT_STOP && state_reg == AFH_ST_RUN && !dropNow
		&& !torqueStop |=> state_reg == AFH_ST_HALT && servoEnable && driveEnable)
		else $error("stop motion did not ramp with enables on");
	a_held_reject: assert property (state_reg == AFH_ST_HELD &&
		state_next == AFH_ST_HELD && moveReq |=> moveRejected && !moveAccepted)
		else $error("move accepted while held");
	a_status_run: assert property (anyFault &&
		sev == AFH_ACT_STATUS && state_reg == AFH_ST_RUN
		|=> state_reg == AFH_ST_RUN && servoEnable)
		else $error("status only fault acted on the axis");
	a_drive_action: assert property (
		act_reg[AFH_F_DRIVE] <= AFH_ACT_DISABLE)
		else $error("drive fault holds an illegal action");
	a_noise_latch: assert property (sync_reg[AFH_F_NOISE]
		|=> faultStatus[AFH_F_NOISE])
		else $error("noise fault not latched");
	a_loss_latch: assert property (sync_reg[AFH_F_LOSS]
		|=> faultStatus[AFH_F_LOSS])
		else $error("loss fault not latched");
	a_poserr_latch: assert property (servoAxis &&
		magOf(posError) > posTolerance |=> faultStatus[AFH_F_POSERR])
		else $error("position error fault not latched");
	a_soft_gate: assert property (!$past(softLimitEn) &&
		!$past(fault_reg[AFH_F_SOFTOT]) |-> !fault_reg[AFH_F_SOFTOT])
		else $error("soft overtravel without limits enabled");
	a_support_set: assert property (axisIsNet &&
		!faultStatus[AFH_F_DRIVE] |=> !faultStatus[AFH_F_DRIVE])
		else $error("unsupported fault latched");
endmodule
`default_nettype wire

//--- sim/afh_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
module afh_drive_model (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic driveEnable,
	input wire logic signed [15:0] ampCmd,
	input wire logic signed [15:0] cmdVel,
	output logic signed [15:0] fbVel,
	output logic signed [15:0] servoOut
);
	logic signed [15:0] velReg;
	logic signed [15:0] velNext;
	// no friction: a disabled motor coasts, so only braking reaches standstill
	always_comb begin
		velNext = velReg;
		if (driveEnable) begin
			velNext = velReg + (ampCmd >>> 3);
		end
	end
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			velReg <= 16'sh0;
		end else begin
			velReg <= velNext;
		end
	end
	assign fbVel = velReg;
	// plain velocity loop standing in for the servo regulator
	assign servoOut = cmdVel - velReg;
endmodule
`default_nettype wire

//--- sim/tb_axis_fault_action_handler.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checkCount++; if ((s) !== (e)) begin errorCnt++; \
	$display("Error %s exp %0h got %0h", n, e, s); end end
module tb_axis_fault_action_handler;
	import afh_pkg::*;
	logic clock = 0, rst_b = 0, axisIsNet = 0, softLimitEn = 1;
	logic servoAxis = 1, driveFaultInEn = 1;
	logic faultClear = 0, cfgWrEn = 0, moveReq = 0;
	logic [7:0] faultPin = 8'h0;
	logic signed [15:0] posError = 16'sh0, moveVel = 16'sh0, fbVel, servoOut;
	logic [15:0] posTolerance = 16'h64, standstillTol = 16'h8;
	logic signed [15:0] stopTorque = 16'sh50, maxDecel = 16'sh32;
	logic [31:0] stopTimeCycles = 32'h14;
	logic [2:0] cfgSel = 3'h0;
	afh_action_e cfgWrData = AFH_ACT_STATUS, cfgRdData, ea;
	logic servoEnable, driveEnable, moveAccepted, moveRejected;
	logic signed [15:0] ampCmd, cmdVel;
	logic [7:0] faultStatus;
	int errorCnt = 0, checkCount = 0, n;

	afh_fault_core afh_fault_core_inst (.clock(clock), .rst_b(rst_b),
		.axisIsNet(axisIsNet), .servoAxis(servoAxis),
		.driveFaultInEn(driveFaultInEn),
		.softLimitEn(softLimitEn), .faultPin(faultPin), .posError(posError),
		.posTolerance(posTolerance), .fbVel(fbVel),
		.standstillTol(standstillTol), .servoOut(servoOut),
		.stopTorque(stopTorque), .stopTimeCycles(stopTimeCycles),
		.maxDecel(maxDecel), .faultClear(faultClear), .cfgWrEn(cfgWrEn),
		.cfgSel(cfgSel), .cfgWrData(cfgWrData), .moveReq(moveReq),
		.moveVel(moveVel), .servoEnable(servoEnable),
		.driveEnable(driveEnable), .ampCmd(ampCmd), .cmdVel(cmdVel),
		.moveAccepted(moveAccepted), .moveRejected(moveRejected),
		.faultStatus(faultStatus), .cfgRdData(cfgRdData));
	afh_drive_model afh_drive_model_inst (.clock(clock), .rst_b(rst_b),
		.driveEnable(driveEnable), .ampCmd(ampCmd), .cmdVel(cmdVel),
		.fbVel(fbVel), .servoOut(servoOut));

	always #2 clock = ~clock;

	function automatic logic expOn(afh_action_e a, logic net);
		return a == AFH_ACT_STOP || a == AFH_ACT_STATUS ||
			(net && a == AFH_ACT_DISABLE);
	endfunction
	task automatic cyc(input int k);
		repeat (k) @(posedge clock);
	endtask
	task automatic setAct(input int i, input afh_action_e a);
		@(posedge clock);
		cfgWrEn <= 1;
		cfgSel <= i[2:0];
		cfgWrData <= a;
		@(posedge clock);
		cfgWrEn <= 0;
		@(negedge clock);
	endtask
	task automatic move(input logic signed [15:0] v, input logic acc);
		@(posedge clock);
		moveReq <= 1;
		moveVel <= v;
		@(posedge clock);
		moveReq <= 0;
		@(negedge clock);
		`CHK("moveAccepted", acc, moveAccepted)
		`CHK("moveRejected", !acc, moveRejected)
		if (acc) `CHK("cmdVel", v, cmdVel)
	endtask
	// position error is computed inside, so it is raised through posError
	task automatic faultOn(input int i);
		@(posedge clock);
		if (i == 3) posError <= 16'shc8;
		else faultPin[i] <= 1;
		cyc(5);
		@(negedge clock);
	endtask
	task automatic faultOff();
		@(posedge clock);
		faultPin <= 8'h0;
		posError <= 16'sh0;
		cyc(3);
		@(posedge clock);
		faultClear <= 1;
		@(posedge clock);
		faultClear <= 0;
		cyc(2);
		@(negedge clock);
		`CHK("faultStatus", 8'h0, faultStatus)
		`CHK("driveEnable", 1'b1, driveEnable)
	endtask
	task automatic complete_run();
		if (errorCnt == 0 && checkCount > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		#200000;
		errorCnt++;
		complete_run();
	end

	initial begin
		void'($urandom(32'hce57cecc));
		cyc(10);
		@(negedge clock);
		`CHK("servoEnable", 1'b0, servoEnable)
		`CHK("cfgRdData", AFH_ACT_DISABLE, cfgRdData)
		@(posedge clock);
		rst_b <= 1;
		cyc(2);
		@(negedge clock);
		`CHK("driveEnable", 1'b1, driveEnable)
		for (int i = 0; i < 8; i++) begin
			for (int a = 0; a < 4; a++) begin
				setAct(i, afh_action_e'(a));
				ea = (i == 0 && a > 1) ? AFH_ACT_DISABLE : afh_action_e'(a);
				`CHK("cfgRdData", ea, cfgRdData)
			end
		end
		for (int i = 0; i < 5; i++) begin
			for (int a = 0; a < 4; a++) begin
				setAct(i, afh_action_e'(a));
				ea = (i == 0 && a > 1) ? AFH_ACT_DISABLE : afh_action_e'(a);
				move(16'shc8 + 16'($urandom_range(600)), 1);
				faultOn(i);
				`CHK("faultStatus", 8'h1 << i, faultStatus)
				`CHK("servoEnable", expOn(ea, 0), servoEnable)
				`CHK("driveEnable", expOn(ea, 0), driveEnable)
				if (!expOn(ea, 0)) `CHK("ampCmd", 16'sh0, ampCmd)
				if (ea == AFH_ACT_STOP) begin
					cyc(30);
					@(negedge clock);
					`CHK("cmdVel", 16'sh0, cmdVel)
				end
				move(16'sh64, ea == AFH_ACT_STATUS);
				faultOff();
			end
		end
		setAct(4, AFH_ACT_SHUTDOWN);
		setAct(5, AFH_ACT_SHUTDOWN);
		@(posedge clock);
		softLimitEn <= 0;
		faultOn(4);
		faultOn(5);
		`CHK("faultStatus", 8'h0, faultStatus)
		`CHK("servoEnable", 1'b1, servoEnable)
		// gated inputs: drive fault needs its input enabled, servo axis needed
		@(posedge clock);
		driveFaultInEn <= 0;
		faultOn(0);
		`CHK("faultStatus", 8'h0, faultStatus)
		@(posedge clock);
		servoAxis <= 0;
		faultOn(3);
		`CHK("faultStatus", 8'h0, faultStatus)
		faultOff();
		@(posedge clock);
		driveFaultInEn <= 1;
		servoAxis <= 1;
		axisIsNet <= 1;
		setAct(7, AFH_ACT_SHUTDOWN);
		faultOn(0);
		`CHK("faultStatus", 8'h0, faultStatus)
		faultOn(7);
		`CHK("driveEnable", 1'b0, driveEnable)
		faultOff();
		setAct(5, AFH_ACT_DISABLE);
		move(16'sh320, 1);
		cyc(60);
		faultOn(5);
		`CHK("servoEnable", 1'b1, servoEnable)
		`CHK("ampCmd", -stopTorque, ampCmd)
		`CHK("cmdVel", 16'sh0, cmdVel)
		cyc(22);
		@(negedge clock);
		`CHK("driveEnable", 1'b0, driveEnable)
		faultOff();
		@(posedge clock);
		stopTimeCycles <= 32'h3e8;
		setAct(6, AFH_ACT_DISABLE);
		move(16'sh320, 1);
		cyc(60);
		faultOn(6);
		n = 0;
		// sampled off the clock edge so the enable seen is settled
		while (driveEnable === 1'b1 && n < 300) begin
			@(negedge clock);
			n++;
		end
		// braking from full speed takes about 80 cycles, far below the limit
		`CHK("stopEarly", 1'b1, n < 150)
		`CHK("brakeHeld", 1'b1, n > 40)
		faultOff();
		complete_run();
	end
endmodule
`default_nettype wire
